//--- verilog/acr_map.svh
/*
 Register offsets, field positions, page codes and reset values of the
 converter configuration bank. Definitions only; included by the bank.
*/
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
// ----------------------------------------
// Page codes
// ----------------------------------------
`define ACR_PAGE_MASTER 8'h80
`define ACR_PAGE_ADC 8'h0F
`define ACR_BANK_IL 16'h6100
// ----------------------------------------
// Offsets
// ----------------------------------------
`define ACR_OFF_ANALOG_PAGE 8'h11
`define ACR_OFF_BANK_LO 8'h03
`define ACR_OFF_BANK_HI 8'h04
`define ACR_OFF_SYNC_CTRL 8'h53
`define ACR_OFF_MASK_APPLY 8'h55
`define ACR_OFF_BUF_BOOST 8'h56
`define ACR_OFF_FORCED_ONE 8'h59
`define ACR_OFF_FOVR_CD 8'h5F
`define ACR_OFF_HPULSE_C 8'h60
`define ACR_OFF_HEN_CD 8'h61
`define ACR_OFF_OFFSET_LOOP 8'h68
`define ACR_OFF_HPULSE_A 8'h6C
`define ACR_OFF_HEN_AB 8'h6D
`define ACR_OFF_PAT_SEL 8'h74
`define ACR_OFF_PAT1_HI 8'h75
`define ACR_OFF_PAT1_LO 8'h76
`define ACR_OFF_PAT2_HI 8'h77
`define ACR_OFF_PAT2_LO 8'h78
`define ACR_OFF_IL_FIX 8'h18
// ----------------------------------------
// Writable bit masks and fields
// ----------------------------------------
`define ACR_MSK_SYNC 8'h40
`define ACR_MSK_MASK_APPLY 8'h10
`define ACR_MSK_BUF_BOOST 8'h08
`define ACR_MSK_FORCED_ONE 8'h20
`define ACR_MSK_HPULSE_HI 8'h10
`define ACR_MSK_HEN 8'h11
`define ACR_MSK_OFFSET 8'h04
`define ACR_MSK_PAT_SEL 8'hF0
`define ACR_MSK_PAT_LO 8'hFC
`define ACR_MSK_IL_FIX 8'h03
`define ACR_MSK_ALL 8'hFF
`define ACR_BIT_SYNC 6
`define ACR_BIT_MASK_APPLY 4
`define ACR_BIT_BOOST 3
`define ACR_BIT_HEN 4
`define ACR_BIT_PULSE_HI 4
`define ACR_BIT_PULSE_LO 0
`define ACR_BIT_OFFSET 2
`define ACR_RESET_VAL 8'h00
`define ACR_DESKEW_WORD 14'h3FFF
`define ACR_TOGGLE_WORD 14'h2AAA
`endif

//--- verilog/acr_pkg.sv
/*
 Types of the converter configuration bank.
 Assumes acr_map.svh is compiled with it.
*/
package acr_pkg;
  typedef enum logic [3:0] {
    ACR_PAT_NORMAL = 4'h0,
    ACR_PAT_ZEROS = 4'h1,
    ACR_PAT_ONES = 4'h2,
    ACR_PAT_TOGGLE = 4'h3,
    ACR_PAT_RAMP = 4'h4,
    ACR_PAT_SINGLE = 4'h6,
    ACR_PAT_DOUBLE = 4'h7,
    ACR_PAT_DESKEW = 4'h8
  } acr_pat_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } acr_req_t;
  typedef struct packed {
    logic sync_ref_ignore;
    logic mask_apply_enable;
    logic input_buffer_boost_a;
    logic forced_one;
    logic [7:0] fast_overrange_level_cd;
    logic harmonic_enable_ab;
    logic harmonic_enable_cd;
    logic interleave_fix_bypass;
    logic offset_loop_disable;
  } acr_ctl_t;
endpackage

//--- verilog/acr_bank.sv
/*
 Configuration bank: paged register file, harmonic arming per channel
 and test pattern generator for channels A and B.
 Assumes a serial front end delivering decoded one-cycle accesses on the
 sample clock; read data is returned one cycle later.
*/
// Notes on behaviour
// - Sync ignore bit masks SYSREF input
// - Mask apply powers down selected mask
// - Level field sets C/D overrange threshold
// - C/D improvement needs enable then pulse
// - A/B improvement needs enable then pulse
// - Pattern select zero passes samples
// - Codes one/two give zeros/ones
// - Code three toggles alternating word
// - Code four outputs incrementing ramp
// - Codes six/seven give user words
// - Code eight outputs deskew word
// - User words split over byte pairs
// - Interleave fix enabled 00, bypassed 11
// - Offset loop bit stops correction
`include "acr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module acr_bank
  import acr_pkg::*;
#(
  parameter int SAMPLE_W = 14
)(
  input wire logic clock, // 40 MHz sample clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire acr_req_t req, // Register access
  output logic [7:0] rdata, // Read data
  output logic rvalid, // Read data valid
  input wire logic [SAMPLE_W-1:0] sample_a, // Converted sample A
  input wire logic [SAMPLE_W-1:0] sample_b, // Converted sample B
  input wire logic sysref_in, // Sync reference pin
  output logic sysref_used, // Sync reference after masking
  output logic [SAMPLE_W-1:0] out_a, // Output sample A
  output logic [SAMPLE_W-1:0] out_b, // Output sample B
  output acr_ctl_t ctl, // Control levels to the core
  output logic [3:0] harmonic_active, // Improvement applied, D..A
  output logic power_down_mask // Apply selected mask
);
  if (SAMPLE_W != 14)
  begin
    $error("acr_bank supports 14-bit samples only");
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] page_reg;
  logic [15:0] bank_reg;
  logic [7:0] sync_reg, mask_reg, boost_reg, forced_reg, fovr_reg;
  logic [7:0] hpc_reg, hcd_reg, hpa_reg, hab_reg;
  logic [7:0] pat_reg, p1h_reg, p1l_reg, p2h_reg, p2l_reg;
  logic [7:0] ilfix_reg, offs_reg;
  logic [7:0] rd_next;
  logic hit;

  function automatic logic sel(input logic [15:0] a, input logic [7:0] off,
                               input logic pg);
    sel = pg && (a[7:0] == off) && (a[15:8] == 8'h00);
  endfunction

  logic pg_m, pg_a, pg_i;
  assign pg_m = (page_reg == `ACR_PAGE_MASTER);
  assign pg_a = (page_reg == `ACR_PAGE_ADC);
  assign pg_i = (bank_reg == `ACR_BANK_IL);

  logic w;
  assign w = req.wr;

  // Global page pointers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      page_reg <= `ACR_RESET_VAL;
      bank_reg <= 16'h0000;
    end
    else if (w)
    begin
      if (sel(req.addr, `ACR_OFF_ANALOG_PAGE, 1'b1))
        page_reg <= req.wdata;
      if (sel(req.addr, `ACR_OFF_BANK_LO, 1'b1))
        bank_reg[7:0] <= req.wdata;
      if (sel(req.addr, `ACR_OFF_BANK_HI, 1'b1))
        bank_reg[15:8] <= req.wdata;
    end
  end

  // Master page; unwritable bits held at zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync_reg <= `ACR_RESET_VAL;
      mask_reg <= `ACR_RESET_VAL;
      boost_reg <= `ACR_RESET_VAL;
      forced_reg <= `ACR_RESET_VAL;
    end
    else if (w)
    begin
      if (sel(req.addr, `ACR_OFF_SYNC_CTRL, pg_m))
        sync_reg <= req.wdata & `ACR_MSK_SYNC;
      if (sel(req.addr, `ACR_OFF_MASK_APPLY, pg_m))
        mask_reg <= req.wdata & `ACR_MSK_MASK_APPLY;
      if (sel(req.addr, `ACR_OFF_BUF_BOOST, pg_m))
        boost_reg <= req.wdata & `ACR_MSK_BUF_BOOST;
      if (sel(req.addr, `ACR_OFF_FORCED_ONE, pg_m))
        forced_reg <= req.wdata & `ACR_MSK_FORCED_ONE;
    end
  end

  // ADC page
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fovr_reg <= `ACR_RESET_VAL;
      hpc_reg <= `ACR_RESET_VAL;
      hcd_reg <= `ACR_RESET_VAL;
      hpa_reg <= `ACR_RESET_VAL;
      hab_reg <= `ACR_RESET_VAL;
      pat_reg <= `ACR_RESET_VAL;
      p1h_reg <= `ACR_RESET_VAL;
      p1l_reg <= `ACR_RESET_VAL;
      p2h_reg <= `ACR_RESET_VAL;
      p2l_reg <= `ACR_RESET_VAL;
    end
    else if (w)
    begin
      if (sel(req.addr, `ACR_OFF_FOVR_CD, pg_a))
        fovr_reg <= req.wdata;
      if (sel(req.addr, `ACR_OFF_HPULSE_C, pg_a))
        hpc_reg <= req.wdata & `ACR_MSK_HPULSE_HI;
      if (sel(req.addr, `ACR_OFF_HEN_CD, pg_a))
        hcd_reg <= req.wdata & `ACR_MSK_HEN;
      if (sel(req.addr, `ACR_OFF_HPULSE_A, pg_a))
        hpa_reg <= req.wdata & `ACR_MSK_HPULSE_HI;
      if (sel(req.addr, `ACR_OFF_HEN_AB, pg_a))
        hab_reg <= req.wdata & `ACR_MSK_HEN;
      if (sel(req.addr, `ACR_OFF_PAT_SEL, pg_a))
        pat_reg <= req.wdata & `ACR_MSK_PAT_SEL;
      if (sel(req.addr, `ACR_OFF_PAT1_HI, pg_a))
        p1h_reg <= req.wdata;
      if (sel(req.addr, `ACR_OFF_PAT1_LO, pg_a))
        p1l_reg <= req.wdata & `ACR_MSK_PAT_LO;
      if (sel(req.addr, `ACR_OFF_PAT2_HI, pg_a))
        p2h_reg <= req.wdata;
      if (sel(req.addr, `ACR_OFF_PAT2_LO, pg_a))
        p2l_reg <= req.wdata & `ACR_MSK_PAT_LO;
    end
  end

  // Interleaving engine page
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ilfix_reg <= `ACR_RESET_VAL;
      offs_reg <= `ACR_RESET_VAL;
    end
    else if (w)
    begin
      if (sel(req.addr, `ACR_OFF_IL_FIX, pg_i))
        ilfix_reg <= req.wdata & `ACR_MSK_IL_FIX;
      if (sel(req.addr, `ACR_OFF_OFFSET_LOOP, pg_i))
        offs_reg <= req.wdata & `ACR_MSK_OFFSET;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always_comb
  begin
    rd_next = `ACR_RESET_VAL;
    hit = 1'b1;
    if (sel(req.addr, `ACR_OFF_ANALOG_PAGE, 1'b1)) rd_next = page_reg;
    else if (sel(req.addr, `ACR_OFF_BANK_LO, 1'b1)) rd_next = bank_reg[7:0];
    else if (sel(req.addr, `ACR_OFF_BANK_HI, 1'b1)) rd_next = bank_reg[15:8];
    else if (sel(req.addr, `ACR_OFF_SYNC_CTRL, pg_m)) rd_next = sync_reg;
    else if (sel(req.addr, `ACR_OFF_MASK_APPLY, pg_m)) rd_next = mask_reg;
    else if (sel(req.addr, `ACR_OFF_BUF_BOOST, pg_m)) rd_next = boost_reg;
    else if (sel(req.addr, `ACR_OFF_FORCED_ONE, pg_m)) rd_next = forced_reg;
    else if (sel(req.addr, `ACR_OFF_FOVR_CD, pg_a)) rd_next = fovr_reg;
    else if (sel(req.addr, `ACR_OFF_HPULSE_C, pg_a)) rd_next = hpc_reg;
    else if (sel(req.addr, `ACR_OFF_HEN_CD, pg_a)) rd_next = hcd_reg;
    else if (sel(req.addr, `ACR_OFF_HPULSE_A, pg_a)) rd_next = hpa_reg;
    else if (sel(req.addr, `ACR_OFF_HEN_AB, pg_a)) rd_next = hab_reg;
    else if (sel(req.addr, `ACR_OFF_PAT_SEL, pg_a)) rd_next = pat_reg;
    else if (sel(req.addr, `ACR_OFF_PAT1_HI, pg_a)) rd_next = p1h_reg;
    else if (sel(req.addr, `ACR_OFF_PAT1_LO, pg_a)) rd_next = p1l_reg;
    else if (sel(req.addr, `ACR_OFF_PAT2_HI, pg_a)) rd_next = p2h_reg;
    else if (sel(req.addr, `ACR_OFF_PAT2_LO, pg_a)) rd_next = p2l_reg;
    else if (sel(req.addr, `ACR_OFF_IL_FIX, pg_i)) rd_next = ilfix_reg;
    else if (sel(req.addr, `ACR_OFF_OFFSET_LOOP, pg_i)) rd_next = offs_reg;
    else hit = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata <= `ACR_RESET_VAL;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      rdata <= (req.rd && hit) ? rd_next : `ACR_RESET_VAL;
    end
  end

  // ----------------------------------------
  // Control levels and sync masking
  // ----------------------------------------
  logic sref_s1, sref_s2;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sref_s1 <= 1'b0;
      sref_s2 <= 1'b0;
      sysref_used <= 1'b0;
      power_down_mask <= 1'b0;
      ctl <= '0;
    end
    else
    begin
      sref_s1 <= sysref_in;
      sref_s2 <= sref_s1;
      sysref_used <= sref_s2 & ~sync_reg[`ACR_BIT_SYNC];
      power_down_mask <= mask_reg[`ACR_BIT_MASK_APPLY];
      ctl.sync_ref_ignore <= sync_reg[`ACR_BIT_SYNC];
      ctl.mask_apply_enable <= mask_reg[`ACR_BIT_MASK_APPLY];
      ctl.input_buffer_boost_a <= boost_reg[`ACR_BIT_BOOST];
      ctl.forced_one <= |forced_reg;
      ctl.fast_overrange_level_cd <= fovr_reg;
      ctl.harmonic_enable_ab <= hab_reg[`ACR_BIT_HEN];
      ctl.harmonic_enable_cd <= hcd_reg[`ACR_BIT_HEN];
      ctl.interleave_fix_bypass <= (ilfix_reg[1:0] == 2'b11);
      ctl.offset_loop_disable <= offs_reg[`ACR_BIT_OFFSET];
    end
  end

  // ----------------------------------------
  // Harmonic arming: latch on pulse falling edge while enabled
  // ----------------------------------------
  logic [3:0] pulse_now, pulse_prev, en_now;
  assign pulse_now = {hcd_reg[`ACR_BIT_PULSE_LO], hpc_reg[`ACR_BIT_PULSE_HI],
                      hab_reg[`ACR_BIT_PULSE_LO], hpa_reg[`ACR_BIT_PULSE_HI]};
  assign en_now = {{2{hcd_reg[`ACR_BIT_HEN]}}, {2{hab_reg[`ACR_BIT_HEN]}}};

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pulse_prev <= 4'h0;
      harmonic_active <= 4'h0;
    end
    else
    begin
      pulse_prev <= pulse_now;
      for (int i = 0; i < 4; i++)
      begin
        if (!en_now[i])
          harmonic_active[i] <= 1'b0;
        else if (pulse_prev[i] && !pulse_now[i])
          harmonic_active[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Test pattern generator
  // ----------------------------------------
  logic [13:0] ramp_reg, user1, user2;
  logic phase_reg;
  logic [13:0] pat_word;
  assign user1 = {p1h_reg, p1l_reg[7:2]};
  assign user2 = {p2h_reg, p2l_reg[7:2]};

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ramp_reg <= 14'h0000;
      phase_reg <= 1'b0;
    end
    else
    begin
      ramp_reg <= ramp_reg + 14'h0001;
      phase_reg <= ~phase_reg;
    end
  end

  always_comb
  begin
    pat_word = 14'h0000;
    unique case (acr_pat_t'(pat_reg[7:4]))
      ACR_PAT_ZEROS: pat_word = 14'h0000;
      ACR_PAT_ONES: pat_word = 14'h3FFF;
      ACR_PAT_TOGGLE:
        pat_word = phase_reg ? ~`ACR_TOGGLE_WORD : `ACR_TOGGLE_WORD;
      ACR_PAT_RAMP: pat_word = ramp_reg;
      ACR_PAT_SINGLE: pat_word = user1;
      ACR_PAT_DOUBLE: pat_word = phase_reg ? user2 : user1;
      ACR_PAT_DESKEW: pat_word = `ACR_DESKEW_WORD;
      default: pat_word = 14'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      out_a <= '0;
      out_b <= '0;
    end
    else if (pat_reg[7:4] == 4'h0)
    begin
      out_a <= sample_a;
      out_b <= sample_b;
    end
    else
    begin
      out_a <= pat_word;
      out_b <= pat_word;
    end
  end
endmodule
`default_nettype wire

//--- bench/acr_bank_sva.sv
/*
 Checker for acr_bank: pattern output A, refused reads, harmonic arming.
 Assumes acr_pkg is compiled first; bound to acr_bank below.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_bank_sva
  import acr_pkg::*;
#(
  parameter int SAMPLE_W = 14
)(
  input wire logic clock, // Sample clock
  input wire logic sys_rst, // Sync reset
  input wire acr_req_t req, // Access
  input wire logic [7:0] rdata, // Read data
  input wire logic [SAMPLE_W-1:0] sample_a, // Sample in
  input wire logic [SAMPLE_W-1:0] out_a, // Output A
  input wire acr_ctl_t ctl, // Controls
  input wire logic [3:0] harmonic_active // Arming
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] page_reg;
  logic [3:0] pat_reg;
  logic [3:0] pat_old;
  logic [3:0] held;
  // ----------------
  // Shadow of page and code
  // ----------------
  always_ff @(posedge clock)
    if (sys_rst)
      page_reg <= 8'h00;
    else if (req.wr && req.addr == 16'h0011)
      page_reg <= req.wdata;
  always_ff @(posedge clock)
    if (sys_rst)
      pat_reg <= 4'h0;
    else if (req.wr && req.addr == 16'h0074 && page_reg == 8'h0F)
      pat_reg <= req.wdata[7:4];
  always_ff @(posedge clock)
    if (sys_rst)
      pat_old <= 4'h0;
    else
      pat_old <= pat_reg;
  assign held = (pat_reg == pat_old) ? pat_reg : 4'hF;
  // ----------------
  // Properties
  // ----------------
  property p_pass;
    held == 4'h0 && !$past(sys_rst) |-> out_a == $past(sample_a);
  endproperty
  a_pass: assert property (p_pass) else $error("pass bad");
  property p_flat;
    held inside {4'h1, 4'h2} |-> out_a == {SAMPLE_W{held[1]}};
  endproperty
  a_flat: assert property (p_flat) else $error("flat bad");
  property p_tog;
    held == 4'h3 && $past(held) == 4'h3 |->
      (out_a == 14'h2AAA || out_a == 14'h1555) && out_a == ~$past(out_a);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle bad");
  property p_ramp;
    held == 4'h4 && $past(held) == 4'h4 |-> out_a == $past(out_a) + 1'b1;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp bad");
  property p_desk;
    held == 4'h8 |-> out_a == 14'h3FFF;
  endproperty
  a_desk: assert property (p_desk) else $error("deskew bad");
  property p_unmap;
    req.rd && req.addr[15:8] != 8'h00 |=> rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped bad");
  property p_hab;
    !ctl.harmonic_enable_ab && $past(!ctl.harmonic_enable_ab) |->
      harmonic_active[1:0] == 2'b00;
  endproperty
  a_hab: assert property (p_hab) else $error("ab arm bad");
  property p_hcd;
    !ctl.harmonic_enable_cd[*2] |-> harmonic_active[3:2] == 2'b00;
  endproperty
  a_hcd: assert property (p_hcd) else $error("cd arm bad");
  c_ramp: cover property (held == 4'h4);
  c_arm: cover property ($rose(harmonic_active[0]));
  c_read: cover property (req.rd ##1 rdata != 8'h00);
endmodule
bind acr_bank acr_bank_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (.clock(clock),
  .sys_rst(sys_rst), .req(req), .rdata(rdata), .sample_a(sample_a),
  .out_a(out_a), .ctl(ctl), .harmonic_active(harmonic_active));
`default_nettype wire

//--- bench/acr_host.sv
/*
 Host model: drives register accesses to the bank; reads last one cycle, writes stay on req until the next task call.
 Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_host
  import acr_pkg::*;
(
  input wire logic clock, // Sample clock
  output acr_req_t req, // Access
  input wire logic [7:0] rdata, // Read data
  input wire logic rvalid // Read valid
);
  initial req = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, d};
  endtask
  task automatic idle();
    @(posedge clock);
    req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [8:0] q);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, 8'h00};
    idle();
    #1 q = {rvalid, rdata};
  endtask
  task automatic page(input logic [7:0] p);
    wr(16'h0011, p);
  endtask
  task automatic bank(input logic [15:0] b);
    wr(16'h0003, b[7:0]);
    wr(16'h0004, b[15:8]);
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
/*
 Self-checking bench for acr_bank: registers, arming, sync, patterns.
 Assumes acr_pkg, acr_bank, acr_host and the checker are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb
  import acr_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sysref_in;
  logic [13:0] sample_a, sample_b, prev_a, prev_b, w1, w2, r0;
  logic [2:0] hist;
  logic [8:0] q;
  logic [3:0] code;
  logic ph;
  int seed = 56336, fails = 0, check_count = 0;
  wire acr_req_t req;
  acr_ctl_t ctl;
  logic [7:0] rdata;
  logic rvalid, sysref_used, power_down_mask;
  logic [13:0] out_a, out_b;
  logic [3:0] harmonic_active;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
  // Address, data, expected arming D..A
  logic [19:0] hv [13] = '{20'h61010, 20'h61000, 20'h6D100, 20'h6C100,
    20'h6C001, 20'h6D111, 20'h6D103, 20'h61103, 20'h60103, 20'h60007,
    20'h61117, 20'h6110F, 20'h6D00C};
  acr_bank #(.SAMPLE_W(14)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .sample_a(sample_a),
    .sample_b(sample_b), .sysref_in(sysref_in), .sysref_used(sysref_used),
    .out_a(out_a), .out_b(out_b), .ctl(ctl),
    .harmonic_active(harmonic_active), .power_down_mask(power_down_mask));
  acr_host u_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    prev_a <= sample_a;
    prev_b <= sample_b;
    hist <= {hist[1:0], sysref_in};
    sample_a <= 14'($random(seed));
    sample_b <= 14'($random(seed));
    sysref_in <= 1'($random(seed));
  end
  // ----------------
  // Helpers
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] x);
    u_host.rd(a, q);
    `CHK("read", {1'b1, x}, q)
  endtask
  task automatic endt(input string s);
    u_host.idle();
    $display("test %s done", s);
  endtask
  task automatic sync_run(input logic ign);
    u_host.wr(16'h0053, {1'b0, ign, 6'h00});
    tick(5);
    `CHK("ignore", ign, ctl.sync_ref_ignore)
    repeat (12)
    begin
      `CHK("sync", ign ? 1'b0 : hist[2], sysref_used)
      @(negedge clock);
    end
  endtask
  function automatic logic [13:0] exp_out(logic [3:0] c, int k, logic p,
    logic [13:0] s);
    case (c)
      4'h0: return s;
      4'h1: return 14'h0000;
      4'h2, 4'h8: return 14'h3FFF;
      4'h3: return ((k + p) % 2) ? 14'h1555 : 14'h2AAA;
      4'h4: return r0 + 14'(k);
      4'h6: return w1;
      default: return ((k + p) % 2) ? w2 : w1;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fails++;
    tally_and_finish();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    `CHK("ctl", '0, ctl)
    rchk(16'h0011, 8'h00);
    rchk(16'h0100, 8'h00);
    u_host.page(8'h80);
    u_host.wr(16'h0055, 8'hFF);
    u_host.wr(16'h0059, 8'h20);
    u_host.wr(16'h0056, 8'hFF);
    rchk(16'h0055, 8'h10);
    rchk(16'h0056, 8'h08);
    `CHK("pdn", 2'b11, {power_down_mask, ctl.mask_apply_enable})
    `CHK("boost", 2'b11, {ctl.input_buffer_boost_a, ctl.forced_one})
    sync_run(1'b1);
    sync_run(1'b0);
    endt("master");
    u_host.page(8'h0F);
    w1 = 14'($random(seed));
    u_host.wr(16'h005F, w1[7:0]);
    tick(3);
    `CHK("fovr", w1[7:0], ctl.fast_overrange_level_cd)
    foreach (hv[i])
    begin
      u_host.wr({8'h00, hv[i][19:12]}, hv[i][11:4]);
      tick(3);
      `CHK("harm", hv[i][3:0], harmonic_active)
    end
    `CHK("hen", 2'b10, {ctl.harmonic_enable_cd, ctl.harmonic_enable_ab})
    endt("harmonic");
    u_host.bank(16'h6100);
    u_host.wr(16'h0018, 8'h01);
    u_host.wr(16'h0068, 8'hFF);
    tick(3);
    `CHK("ilfix", 2'b01, {ctl.interleave_fix_bypass, ctl.offset_loop_disable})
    u_host.wr(16'h0018, 8'hFF);
    rchk(16'h0018, 8'h03);
    rchk(16'h0068, 8'h04);
    `CHK("bypass", 1'b1, ctl.interleave_fix_bypass)
    w1 = 14'($random(seed));
    w2 = ~w1; // Every bit flips between words
    u_host.wr(16'h0075, w1[13:6]);
    u_host.wr(16'h0076, {w1[5:0], 2'b11});
    u_host.wr(16'h0077, w2[13:6]);
    u_host.wr(16'h0078, {w2[5:0], 2'b11});
    rchk(16'h0078, {w2[5:0], 2'b00});
    foreach (codes[i])
    begin
      code = codes[i];
      u_host.wr(16'h0074, {code, 4'hF});
      tick(3);
      r0 = out_a;
      ph = (out_a != exp_out(code, 0, 1'b0, prev_a));
      for (int k = 0; k < 8; k++)
      begin
        `CHK("out_a", exp_out(code, k, ph, prev_a), out_a)
        `CHK("out_b", exp_out(code, k, ph, prev_b), out_b)
        @(negedge clock);
      end
    end
    u_host.page(8'h80);
    u_host.wr(16'h0074, 8'h10);
    u_host.page(8'h0F);
    rchk(16'h0074, 8'h80);
    endt("pattern");
    tally_and_finish();
  end
endmodule
`default_nettype wire
